// ### shared/status_led_regs.vh
// Constants for the status LED driver: timing, register map, field positions, protocol state codes.
// Assumes a 50 MHz aclk; included by bare name from the design file.
`ifndef STATUS_LED_REGS_VH
`define STATUS_LED_REGS_VH

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_HZ 50000000
`define SLOT_MS 200
`define SLOT_CYCLES ((`CLK_HZ / 1000) * `SLOT_MS)
`define FLICKER_MS 50
`define FLICKER_CYCLES ((`CLK_HZ / 1000) * `FLICKER_MS)
`define SLOTS_PER_CYCLE 6

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_IP_STATE 12'h004
`define REG_BUS_STATE 12'h008
`define REG_PORT_STATE 12'h00c
`define REG_LED_STATUS 12'h010

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define CTRL_MODE_BIT 0
`define CTRL_RESET 32'h00000000
`define MODE_RESET 1'b0
`define IP_STATE_RESET 6'h00
`define BUS_STATE_RESET 7'h01
`define PORT_STATE_RESET 4'h0
`define IP_POWERED_BIT 0
`define IP_HAS_ADDR_BIT 1
`define IP_CONNECTED_BIT 2
`define IP_TIMEOUT_BIT 3
`define IP_DUP_ADDR_BIT 4
`define IP_SELF_TEST_BIT 5
`define BUS_STATE_LSB 0
`define BUS_CFG_ERR_BIT 4
`define BUS_SYNC_ERR_BIT 5
`define BUS_WDOG_BIT 6
`define PORT_LINK_LSB 0
`define PORT_DATA_LSB 2

// ------------------------------------------------------------------
// Protocol state encodings
// ------------------------------------------------------------------
`define ST_INIT 4'h1
`define ST_PREOP 4'h2
`define ST_SAFEOP 4'h4
`define ST_OP 4'h8

`endif

// ### src/fieldbus_status_led_driver.v
// Status LED driver for a multi-protocol Ethernet option module.
// Assumes software on AXI4-Lite supplies protocol and port state; LEDs active high.
`timescale 1ns/1ps
`include "status_led_regs.vh"

// Operation
// - IP mode: status LED dark when unpowered or without address.
// - IP mode: blink green with address but no connection.
// - IP mode: steady green while connected and transferring.
// - IP mode: blink red after connection lost by timeout.
// - IP mode: steady red on duplicate address.
// - IP mode: alternate red and green during self test.
// - IP mode: link LED green when connected, activity yellow during data.
// - Fieldbus mode: activity LEDs always dark.
// - Fieldbus mode: link LED dark with no physical connection.
// - Fieldbus mode: link LED steady green when connected, no telegrams.
// - Fieldbus mode: link LED flickers green with telegram exchange.
// - Fieldbus INIT without error: status LED dark.
// - Fieldbus PRE-OPERATIONAL: status LED blinks green.
// - Fieldbus SAFE-OPERATIONAL: single green flash per cycle.
// - Fieldbus OPERATIONAL: steady green.
// - Fieldbus configuration error: blink red.
// - Fieldbus not synchronised: single red flash per cycle.
// - Fieldbus watchdog timeout: double red flash per cycle.
// - Patterns built from 200 ms lit or dark slots, repeating each cycle.
// - Two single-colour LEDs per port plus one bicolour status LED.
module fieldbus_status_led_driver #(
  parameter SLOT_CYCLES = `SLOT_CYCLES,
  parameter FLICKER_CYCLES = `FLICKER_CYCLES,
  parameter NPORTS = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg port1_activity_led,
  output reg port2_activity_led,
  output reg port1_link_led,
  output reg port2_link_led,
  output reg module_status_led_green,
  output reg module_status_led_red
);

  // ------------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------------
  reg mode_q;
  reg [5:0] ip_state_q;
  reg [6:0] bus_state_q;
  reg [3:0] port_state_q;
  // Write channel holding registers
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg aw_have_q;
  reg w_have_q;

  // ------------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------------
  // Free-running counters; the pattern phase never restarts on a state change
  reg [31:0] slot_cnt_q;
  reg [31:0] flick_cnt_q;
  reg [2:0] slot_idx_q;
  reg flick_q;
  // End-of-period strobes
  wire slot_tick = (slot_cnt_q == SLOT_CYCLES - 1);
  wire flick_tick = (flick_cnt_q == FLICKER_CYCLES - 1);

  // Slot counter, six slots per pattern cycle, then repeat
  always @(posedge aclk) begin
    if (!aresetn) begin
      slot_cnt_q <= 32'h00000000;
      slot_idx_q <= 3'h0;
    end else begin
      slot_cnt_q <= slot_tick ? 32'h00000000 : slot_cnt_q + 32'h00000001;
      if (slot_tick) begin
        slot_idx_q <= (slot_idx_q == `SLOTS_PER_CYCLE - 1) ? 3'h0 : slot_idx_q + 3'h1;
      end
    end
  end

  // Flicker divider, kept apart so its rate can differ from the slot length
  always @(posedge aclk) begin
    if (!aresetn) begin
      flick_cnt_q <= 32'h00000000;
      flick_q <= 1'b0;
    end else begin
      flick_cnt_q <= flick_tick ? 32'h00000000 : flick_cnt_q + 32'h00000001;
      if (flick_tick) begin
        flick_q <= ~flick_q;
      end
    end
  end

  // Slot patterns: lit or dark per 200 ms slot
  wire pat_blink = ~slot_idx_q[0];
  wire pat_single = (slot_idx_q == 3'h0);
  wire pat_double = (slot_idx_q == 3'h0) || (slot_idx_q == 3'h2);

  // ------------------------------------------------------------------
  // LED decision
  // ------------------------------------------------------------------
  reg grn_d;
  reg red_d;
  wire [NPORTS-1:0] link_d;
  wire [NPORTS-1:0] act_d;

  // Field views of the stored state
  wire ip_pwr = ip_state_q[`IP_POWERED_BIT];
  wire ip_addr = ip_state_q[`IP_HAS_ADDR_BIT];
  wire ip_conn = ip_state_q[`IP_CONNECTED_BIT];
  wire ip_tmo = ip_state_q[`IP_TIMEOUT_BIT];
  wire ip_dup = ip_state_q[`IP_DUP_ADDR_BIT];
  wire ip_test = ip_state_q[`IP_SELF_TEST_BIT];
  wire [3:0] bus_st = bus_state_q[3:0];
  wire bus_cfg = bus_state_q[`BUS_CFG_ERR_BIT];
  wire bus_sync = bus_state_q[`BUS_SYNC_ERR_BIT];
  wire bus_wdog = bus_state_q[`BUS_WDOG_BIT];

  // One-hot protocol state views; any other code shows dark
  wire st_op = (bus_st == `ST_OP);
  wire st_safeop = (bus_st == `ST_SAFEOP);
  wire st_preop = (bus_st == `ST_PREOP);

  // Status LED, most severe condition first
  always @* begin
    grn_d = 1'b0;
    red_d = 1'b0;
    // IP protocol: a lost connection ranks with the errors
    if (!mode_q) begin
      if (ip_test) begin
        grn_d = pat_blink;
        red_d = ~pat_blink;
      end else if (ip_dup) begin
        red_d = 1'b1;
      end else if (ip_tmo) begin
        red_d = pat_blink;
      end else if (!ip_pwr || !ip_addr) begin
        grn_d = 1'b0;
      end else if (ip_conn) begin
        grn_d = 1'b1;
      end else begin
        grn_d = pat_blink;
      end
    end else begin
      // Fieldbus: watchdog ranks with a duplicate address
      if (bus_wdog) begin
        red_d = pat_double;
      end else if (bus_cfg) begin
        red_d = pat_blink;
      end else if (bus_sync) begin
        red_d = pat_single;
      end else if (st_op) begin
        grn_d = 1'b1;
      end else if (st_safeop) begin
        grn_d = pat_single;
      end else if (st_preop) begin
        grn_d = pat_blink;
      end else begin
        grn_d = 1'b0;
      end
    end
  end

  // Port LEDs, one link and one activity per port
  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : g_port
      wire lk = port_state_q[`PORT_LINK_LSB + g];
      wire dt = port_state_q[`PORT_DATA_LSB + g];
      reg link_r;
      reg act_r;
      // Fieldbus link flickers on telegrams; activity has no meaning there
      always @* begin
        link_r = 1'b0;
        act_r = 1'b0;
        if (!mode_q) begin
          link_r = lk;
          act_r = dt;
        end else begin
          act_r = 1'b0;
          if (!lk) begin
            link_r = 1'b0;
          end else if (dt) begin
            link_r = flick_q;
          end else begin
            link_r = 1'b1;
          end
        end
      end
      assign link_d[g] = link_r;
      assign act_d[g] = act_r;
    end
  endgenerate

  // Registered LED outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      module_status_led_green <= 1'b0;
      module_status_led_red <= 1'b0;
      port1_link_led <= 1'b0;
      port2_link_led <= 1'b0;
      port1_activity_led <= 1'b0;
      port2_activity_led <= 1'b0;
    end else begin
      module_status_led_green <= grn_d;
      module_status_led_red <= red_d;
      port1_link_led <= link_d[0];
      port2_link_led <= link_d[1];
      port1_activity_led <= act_d[0];
      port2_activity_led <= act_d[1];
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write side
  // ------------------------------------------------------------------
  // Response codes
  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  // Either channel may arrive first; the held copy wins once latched
  wire aw_ok = aw_have_q || s_axi_awvalid;
  wire w_ok = w_have_q || s_axi_wvalid;
  wire [7:0] wa = aw_have_q ? aw_addr_q : s_axi_awaddr[7:0];
  wire [31:0] wd = w_have_q ? w_data_q : s_axi_wdata;
  wire [3:0] ws = w_have_q ? w_strb_q : s_axi_wstrb;
  wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
  reg wa_hi_q;

  // Write decode; upper address bits come from the latch once the address is held
  wire wa_hi = aw_have_q ? wa_hi_q : (s_axi_awaddr[11:8] != 4'h0);
  wire wa_ctrl = (wa == `REG_CTRL);
  wire wa_ip = (wa == `REG_IP_STATE);
  wire wa_bus = (wa == `REG_BUS_STATE);
  wire wa_port = (wa == `REG_PORT_STATE);
  wire wa_led = (wa == `REG_LED_STATUS);
  wire wa_map = !wa_hi && (wa_ctrl || wa_ip || wa_bus || wa_port || wa_led);

  // Address and data taken in either order; response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      wa_hi_q <= 1'b0;
      mode_q <= `MODE_RESET;
      ip_state_q <= `IP_STATE_RESET;
      bus_state_q <= `BUS_STATE_RESET;
      port_state_q <= `PORT_STATE_RESET;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      // Address alone: hold it until the data arrives
      if (s_axi_awvalid && !aw_have_q && !s_axi_awready && !do_wr) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr[7:0];
        wa_hi_q <= s_axi_awaddr[11:8] != 4'h0;
        s_axi_awready <= 1'b1;
      end
      // Data alone: hold it until the address arrives
      if (s_axi_wvalid && !w_have_q && !s_axi_wready && !do_wr) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      // Both present: answer once and write the register
      if (do_wr && !s_axi_awready && !s_axi_wready) begin
        s_axi_awready <= !aw_have_q;
        s_axi_wready <= !w_have_q;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        // Only byte 0 carries fields; upper lanes ignored
        if (!wa_map) begin
          s_axi_bresp <= RESP_SLVERR;
        end else if (!ws[0]) begin
          // Low lane disabled: answered OKAY, nothing changes
          s_axi_bresp <= RESP_OKAY;
        end else if (wa_ctrl) begin
          mode_q <= wd[`CTRL_MODE_BIT];
        end else if (wa_ip) begin
          ip_state_q <= wd[5:0];
        end else if (wa_bus) begin
          bus_state_q <= wd[6:0];
        end else if (wa_port) begin
          port_state_q <= wd[3:0];
        end else begin
          // Status word is read-only; a write is accepted and dropped
          s_axi_bresp <= RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read side
  // ------------------------------------------------------------------
  // Read decode; upper address bits must be clear for any register
  wire [7:0] ra = s_axi_araddr[7:0];
  wire ra_hi = s_axi_araddr[11:8] != 4'h0;
  wire ra_ctrl = !ra_hi && (ra == `REG_CTRL);
  wire ra_ip = !ra_hi && (ra == `REG_IP_STATE);
  wire ra_bus = !ra_hi && (ra == `REG_BUS_STATE);
  wire ra_port = !ra_hi && (ra == `REG_PORT_STATE);
  wire ra_led = !ra_hi && (ra == `REG_LED_STATUS);

  // Live LED state plus slot index, for software diagnosis
  wire [31:0] led_word = {22'h000000, slot_idx_q, port2_activity_led, port1_activity_led,
    port2_link_led, port1_link_led, flick_q, module_status_led_red, module_status_led_green};

  // One read at a time; unmapped addresses answer SLVERR with zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h00000000;
        if (ra_ctrl) begin
          s_axi_rdata <= {31'h00000000, mode_q};
        end else if (ra_ip) begin
          s_axi_rdata <= {26'h0000000, ip_state_q};
        end else if (ra_bus) begin
          s_axi_rdata <= {25'h0000000, bus_state_q};
        end else if (ra_port) begin
          s_axi_rdata <= {28'h0000000, port_state_q};
        end else if (ra_led) begin
          s_axi_rdata <= led_word;
        end else begin
          // Unmapped or upper address bits set: error with zero data
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // fieldbus_status_led_driver

// ### sim/status_led_chk.sv
// Checker: LED pins against register state shadowed off the write channel.
// Assumes the master offers address and data together, held to the handshake.
`timescale 1ns/1ps
`include "status_led_regs.vh"
module status_led_chk #(
  parameter SLOT_CYCLES = 20,
  parameter FLICKER_CYCLES = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire port1_activity_led,
  input wire port2_activity_led,
  input wire port1_link_led,
  input wire port2_link_led,
  input wire module_status_led_green,
  input wire module_status_led_red
);
  // ----------------------------------------
  // Shadow state and properties
  // ----------------------------------------
  reg mode_q;
  reg [5:0] ip_q;
  reg [6:0] bus_q;
  reg [3:0] port_q;
  wire g = module_status_led_green;
  wire r = module_status_led_red;
  wire [3:0] leds = {port2_activity_led, port1_activity_led, port2_link_led, port1_link_led};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Taken at the handshake, one edge behind the register, so in step with the LED lag
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 1'b0;
      ip_q <= 6'h00;
      bus_q <= 7'h01;
      port_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == `REG_CTRL) mode_q <= s_axi_wdata[0];
      if (s_axi_awaddr == `REG_IP_STATE) ip_q <= s_axi_wdata[5:0];
      if (s_axi_awaddr == `REG_BUS_STATE) bus_q <= s_axi_wdata[6:0];
      if (s_axi_awaddr == `REG_PORT_STATE) port_q <= s_axi_wdata[3:0];
    end
  end
  AST_BICOLOUR: assert property (!(g && r))
    else $error("status LED lit in both colours");
  AST_FB_ACT_DARK: assert property (mode_q |-> leds[3:2] == 2'b00)
    else $error("activity LED lit in fieldbus mode");
  AST_FB_LINK_DARK: assert property (mode_q && !port_q[0] |-> !port1_link_led)
    else $error("link LED lit without a connection");
  AST_FB_LINK2_DARK: assert property (mode_q && !port_q[1] |-> !port2_link_led)
    else $error("second link LED lit without a connection");
  AST_FB_LINK_ON: assert property (mode_q && port_q[0] && !port_q[2] |-> port1_link_led)
    else $error("link LED not steady while idle");
  AST_IP_PORTS: assert property (!mode_q |-> leds == port_q)
    else $error("port LEDs differ from port state");
  AST_FB_INIT_DARK: assert property (mode_q && bus_q == 7'h01 |-> !g && !r)
    else $error("status LED lit in init");
  AST_FB_OP_GREEN: assert property (mode_q && bus_q == 7'h08 |-> g && !r)
    else $error("status LED not green in operational");
  AST_IP_DUP_RED: assert property (!mode_q && ip_q[5:4] == 2'b01 |-> r && !g)
    else $error("status LED not red on duplicate address");
endmodule // status_led_chk

// ### sim/led_panel.sv
// Operator's view of the LED pins: lit cycles and link toggles per window.
// Assumes run is held high for one whole pattern cycle at a time.
`timescale 1ns/1ps
module led_panel (
  input wire aclk,
  input wire run,
  input wire green,
  input wire red,
  input wire link,
  output reg [7:0] green_cnt,
  output reg [7:0] red_cnt,
  output reg [7:0] link_on,
  output reg [7:0] link_chg
);
  // ----------------------------------------
  // Counters
  // ----------------------------------------
  reg link_q;
  // Cleared while run is low, so counts hold no matter the pattern phase
  always @(posedge aclk) begin
    link_q <= link;
    if (!run) begin
      {green_cnt, red_cnt, link_on, link_chg} <= 32'h0;
    end else begin
      green_cnt <= green_cnt + {7'h00, green};
      red_cnt <= red_cnt + {7'h00, red};
      link_on <= link_on + {7'h00, link};
      link_chg <= link_chg + {7'h00, link != link_q};
    end
  end
endmodule // led_panel

// ### sim/tb.sv
// Testbench top: drives the register bus and judges the LEDs through the panel.
// Assumes 20-cycle slots and a 5-cycle flicker in the driver instance.
`timescale 1ns/1ps
`include "status_led_regs.vh"
module tb;
  localparam [7:0] SL = 8'h14;
  localparam [7:0] WIN = SL * 8'h06;
  localparam [7:0] HALF = WIN >> 1;
  localparam [7:0] TOG = WIN / 8'h05;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run;
  reg [11:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire port1_activity_led, port2_activity_led, port1_link_led, port2_link_led, grn, red;
  wire [7:0] green_cnt, red_cnt, link_on, link_chg;
  integer error_cnt, tests_run, cyc;
  fieldbus_status_led_driver #(.SLOT_CYCLES(20), .FLICKER_CYCLES(5)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port1_activity_led(port1_activity_led), .port2_activity_led(port2_activity_led),
    .port1_link_led(port1_link_led), .port2_link_led(port2_link_led),
    .module_status_led_green(grn), .module_status_led_red(red));
  led_panel u_panel (.aclk(aclk), .run(run), .green(grn), .red(red), .link(port1_link_led),
    .green_cnt(green_cnt), .red_cnt(red_cnt), .link_on(link_on), .link_chg(link_chg));
  // ----------------------------------------
  // Clock, time limit, compare and bus tasks
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Whole run needs about 2400 cycles
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wrchk(input [11:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask
  // One full pattern cycle watched; counts do not depend on phase
  task meas(input [11:0] a, input [31:0] d, input lk, input [15:0] e);
    begin
      wrchk(a, d, 2'b00);
      repeat (2) @(posedge aclk);
      run <= 1'b1;
      repeat (WIN) @(posedge aclk);
      run <= 1'b0;
      #1;
      chk(lk ? {16'h0, link_on, link_chg} : {16'h0, green_cnt, red_cnt}, {16'h0, e});
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    begin
      rdchk(`REG_CTRL, 32'h0, 2'b00);
      rdchk(`REG_BUS_STATE, 32'h1, 2'b00);
      rdchk(12'h014, 32'h0, 2'b10);
      wrchk(12'h100, 32'h1, 2'b10);
      wrchk(12'h018, 32'h1, 2'b10);
      wrchk(`REG_LED_STATUS, 32'h7f, 2'b00);
      s_axi_wstrb <= 4'he;
      wrchk(`REG_CTRL, 32'h1, 2'b00);
      s_axi_wstrb <= 4'hf;
      rdchk(`REG_CTRL, 32'h0, 2'b00);
      wrchk(`REG_PORT_STATE, 32'h5, 2'b00);
      rdchk(`REG_PORT_STATE, 32'h5, 2'b00);
      chk({28'h0, port2_activity_led, port1_activity_led, port2_link_led, port1_link_led}, 5);
    end
  endtask
  task t_ip;
    begin
      meas(`REG_IP_STATE, 32'h00, 1'b0, 16'h0000);
      meas(`REG_IP_STATE, 32'h01, 1'b0, 16'h0000);
      meas(`REG_IP_STATE, 32'h03, 1'b0, {HALF, 8'h00});
      meas(`REG_IP_STATE, 32'h07, 1'b0, {WIN, 8'h00});
      meas(`REG_IP_STATE, 32'h0b, 1'b0, {8'h00, HALF});
      meas(`REG_IP_STATE, 32'h17, 1'b0, {8'h00, WIN});
      meas(`REG_IP_STATE, 32'h1b, 1'b0, {8'h00, WIN});
      meas(`REG_IP_STATE, 32'h37, 1'b0, {HALF, HALF});
    end
  endtask
  task t_bus;
    begin
      wrchk(`REG_CTRL, 32'h1, 2'b00);
      meas(`REG_BUS_STATE, 32'h01, 1'b0, 16'h0000);
      meas(`REG_BUS_STATE, 32'h02, 1'b0, {HALF, 8'h00});
      meas(`REG_BUS_STATE, 32'h04, 1'b0, {SL, 8'h00});
      meas(`REG_BUS_STATE, 32'h08, 1'b0, {WIN, 8'h00});
      meas(`REG_BUS_STATE, 32'h18, 1'b0, {8'h00, HALF});
      meas(`REG_BUS_STATE, 32'h28, 1'b0, {8'h00, SL});
      meas(`REG_BUS_STATE, 32'h58, 1'b0, {8'h00, SL << 1});
      meas(`REG_BUS_STATE, 32'h38, 1'b0, {8'h00, HALF});
    end
  endtask
  task t_link;
    begin
      meas(`REG_PORT_STATE, 32'h0, 1'b1, 16'h0000);
      meas(`REG_PORT_STATE, 32'h1, 1'b1, {WIN, 8'h00});
      meas(`REG_PORT_STATE, 32'h5, 1'b1, {HALF, TOG});
      chk({30'h0, port2_activity_led, port1_activity_led}, 32'h0);
      wrchk(`REG_PORT_STATE, 32'h2, 2'b00);
      repeat (2) @(posedge aclk);
      chk({30'h0, port2_link_led, port1_link_led}, 32'h2);
    end
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    run = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_ip;
    t_bus;
    t_link;
    end_sim;
  end
endmodule // tb
bind fieldbus_status_led_driver status_led_chk #(.SLOT_CYCLES(SLOT_CYCLES),
  .FLICKER_CYCLES(FLICKER_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .port1_activity_led(port1_activity_led),
  .port2_activity_led(port2_activity_led), .port1_link_led(port1_link_led),
  .port2_link_led(port2_link_led), .module_status_led_green(module_status_led_green),
  .module_status_led_red(module_status_led_red));
